// ### src/slpsc_pkg.sv
// Constants, command codes and mode encoding of the low-power state control block
package slpsc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ROW_W = 12;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 120;
  localparam int SR_EXIT_RAW = (SELF_REFRESH_EXIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_EXIT_CYCLES = (SR_EXIT_RAW < 2) ? 2 : SR_EXIT_RAW;
  localparam int EXIT_CNT_W = 4;
  localparam logic [EXIT_CNT_W-1:0] SR_EXIT_LAST = EXIT_CNT_W'(SR_EXIT_CYCLES - 1);
  localparam int REFRESH_PERIOD_MS = 64;
  localparam int PD_LIMIT_DEFAULT = REFRESH_PERIOD_MS * CLK_MHZ * 1000;
  localparam int PD_CNT_W = 23;
  localparam int SELF_REFRESH_INTERVAL_NS = 7800;
  localparam int SR_INTERVAL_CYCLES = (SELF_REFRESH_INTERVAL_NS * CLK_MHZ) / 1000;
  localparam int INTV_CNT_W = 9;
  localparam logic [INTV_CNT_W-1:0] INTV_LAST = INTV_CNT_W'(SR_INTERVAL_CYCLES - 1);
  localparam int REFRESH_BUSY_NS = 100;
  localparam int REFRESH_BUSY_CYCLES = (REFRESH_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_CNT_W = 3;
  localparam logic [BUSY_CNT_W-1:0] BUSY_LOAD = BUSY_CNT_W'(REFRESH_BUSY_CYCLES);
  localparam logic [ROW_W-1:0] ROW_RST = 12'h000;
  localparam logic [PD_CNT_W-1:0] PD_CNT_RST = 23'h000000;
  localparam logic [EXIT_CNT_W-1:0] EXIT_CNT_RST = 4'h0;
  localparam logic [INTV_CNT_W-1:0] INTV_RST = 9'h000;
  localparam logic [BUSY_CNT_W-1:0] BUSY_RST = 3'h0;
  // Command code is {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DEEP_PD = 4'h6;
  localparam logic [3:0] CMD_RST = 4'hf;
  typedef enum logic [7:0] {
    MODE_NORMAL = 8'h01,
    MODE_SUSPEND = 8'h02,
    MODE_SELF_REF = 8'h04,
    MODE_SR_EXIT = 8'h08,
    MODE_PD_PRE = 8'h10,
    MODE_PD_ACT = 8'h20,
    MODE_DEEP_PD = 8'h40,
    MODE_INIT_WAIT = 8'h80
  } slpsc_mode_t;
endpackage

// ### src/slpsc_osc_if.sv
// Link between the mode logic and the self refresh timing generator
`timescale 1ns/10ps
interface slpsc_osc_if import slpsc_pkg::*; ();
  logic run;
  logic ext_refresh;
  logic tick;
  logic busy;
  logic [ROW_W-1:0] row;
  modport ctrl (output run, output ext_refresh, input tick, input busy, input row);
  modport osc (input run, input ext_refresh, output tick, output busy, output row);
endinterface

// ### src/slpsc_self_osc.sv
// Self refresh timing generator and shared refresh row counter
`timescale 1ns/10ps
module slpsc_self_osc
  import slpsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  slpsc_osc_if.osc osc
);
  typedef struct packed {
    logic [INTV_CNT_W-1:0] intv;
    logic [BUSY_CNT_W-1:0] busy;
    logic tick;
    logic [ROW_W-1:0] row;
  } slpsc_osc_state_t;

  slpsc_osc_state_t state;
  slpsc_osc_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.busy != BUSY_RST)
    begin
      next_state.busy = state.busy - 1'b1;
    end
    if (osc.run)
    begin
      // Own interval timer, no external command needed
      if (state.intv == INTV_LAST)
      begin
        next_state.intv = INTV_RST;
        next_state.tick = 1'b1;
        next_state.busy = BUSY_LOAD;
        next_state.row = state.row + 1'b1;
      end
      else
      begin
        next_state.intv = state.intv + 1'b1;
      end
    end
    else
    begin
      next_state.intv = INTV_RST;
      if (osc.ext_refresh)
      begin
        next_state.busy = BUSY_LOAD;
        next_state.row = state.row + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state <= '{intv: INTV_RST, busy: BUSY_RST, tick: 1'b0, row: ROW_RST};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign osc.tick = state.tick;
  assign osc.busy = (state.busy != BUSY_RST);
  assign osc.row = state.row;

  a_tick_spacing: assert property (@(posedge mclk_i) disable iff (srst_i)
    osc.tick |=> !osc.tick [*8])
    else $error("Self refresh ticks too close");
  a_tick_row: assert property (@(posedge mclk_i) disable iff (srst_i)
    osc.tick |-> osc.row == $past(osc.row) + 1'b1)
    else $error("Row counter did not advance on self refresh");
  a_tick_busy: assert property (@(posedge mclk_i) disable iff (srst_i)
    osc.tick |-> osc.busy [*4])
    else $error("Internal refresh busy too short");
endmodule

// ### src/slpsc_ctrl.sv
// Clock-enable driven low-power mode control of the memory device
`timescale 1ns/10ps
// Notes on behaviour
// - Refresh code with clock-enable low and idle banks enters self refresh.
// - In self refresh only clock-enable is observed; it stays low.
// - Self refresh runs an own timer and refreshes rows itself.
// - Clock-enable low with no-operation and no access enters power-down.
// - Idle banks give precharge power-down, an open row gives active.
// - Power-down turns off all buffers except clock-enable.
// - No-operation with clock-enable high ends power-down at the next edge.
// - Deep power-down code with clock-enable low and idle banks enters it.
// - Deep power-down removes array power; contents are lost.
// - Clock-enable low during a burst enters clock suspend.
// - Each low sample of clock-enable skips the next internal edge.
// - Suspended edges ignore commands, keep output data, hold counters.
// - Clock-enable high leaves suspend; operation resumes next edge.
module slpsc_ctrl
  import slpsc_pkg::*;
#(
  parameter int PD_LIMIT_CYCLES = PD_LIMIT_DEFAULT
)
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic access_busy_i,
  input wire logic banks_open_i,
  input wire logic init_done_i,
  output logic cmd_enable_o,
  output logic int_clk_en_o,
  output logic out_hold_o,
  output logic in_buf_en_o,
  output logic out_buf_en_o,
  output logic suspend_o,
  output logic self_refresh_o,
  output logic sr_exit_o,
  output logic pd_precharge_o,
  output logic pd_active_o,
  output logic deep_pd_o,
  output logic array_power_o,
  output logic data_lost_o,
  output logic init_required_o,
  output logic pd_overdue_o,
  output logic internal_refresh_o,
  output logic [ROW_W-1:0] refresh_row_o
);
  localparam logic [PD_CNT_W-1:0] PD_LIMIT = PD_CNT_W'(PD_LIMIT_CYCLES);

  typedef struct packed {
    logic cke_m;
    logic cke_s;
    logic [3:0] cmd_m;
    logic [3:0] cmd_s;
    slpsc_mode_t mode;
    logic [EXIT_CNT_W-1:0] exit_cnt;
    logic [PD_CNT_W-1:0] pd_cnt;
    logic pd_overdue;
    logic data_lost;
  } slpsc_ctrl_state_t;

  slpsc_ctrl_state_t state;
  slpsc_ctrl_state_t next_state;
  slpsc_osc_if osc_link ();
  logic cmd_nop;
  logic in_pd;

  slpsc_self_osc u_osc (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .osc(osc_link.osc)
  );

  // Inhibit (chip select high) counts as a no-operation
  assign cmd_nop = state.cmd_s[3] || (state.cmd_s == CMD_NOP);
  assign in_pd = (state.mode == MODE_PD_PRE) || (state.mode == MODE_PD_ACT);

  always_comb
  begin
    next_state = state;
    next_state.cke_m = cke_i;
    next_state.cke_s = state.cke_m;
    next_state.cmd_m = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    next_state.cmd_s = state.cmd_m;
    unique case (state.mode)
      MODE_NORMAL:
      begin
        if (!state.cke_s)
        begin
          if (access_busy_i)
          begin
            next_state.mode = MODE_SUSPEND;
          end
          else if ((state.cmd_s == CMD_REFRESH) && !banks_open_i)
          begin
            next_state.mode = MODE_SELF_REF;
          end
          else if ((state.cmd_s == CMD_DEEP_PD) && !banks_open_i)
          begin
            next_state.mode = MODE_DEEP_PD;
            next_state.data_lost = 1'b1;
          end
          else if (cmd_nop)
          begin
            next_state.mode = banks_open_i ? MODE_PD_ACT : MODE_PD_PRE;
          end
        end
      end
      MODE_SUSPEND:
      begin
        if (state.cke_s)
        begin
          next_state.mode = MODE_NORMAL;
        end
      end
      MODE_SELF_REF:
      begin
        // Every input but clock-enable is ignored here
        if (state.cke_s)
        begin
          next_state.mode = MODE_SR_EXIT;
          next_state.exit_cnt = SR_EXIT_LAST;
        end
      end
      MODE_SR_EXIT:
      begin
        // Wait out the exit time and any refresh still running
        if (state.exit_cnt != EXIT_CNT_RST)
        begin
          next_state.exit_cnt = state.exit_cnt - 1'b1;
        end
        else if (!osc_link.busy)
        begin
          next_state.mode = MODE_NORMAL;
        end
      end
      MODE_PD_PRE, MODE_PD_ACT:
      begin
        if (state.cke_s && cmd_nop)
        begin
          next_state.mode = MODE_NORMAL;
        end
      end
      MODE_DEEP_PD:
      begin
        if (state.cke_s)
        begin
          next_state.mode = MODE_INIT_WAIT;
        end
      end
      MODE_INIT_WAIT:
      begin
        if (init_done_i)
        begin
          next_state.mode = MODE_NORMAL;
          next_state.data_lost = 1'b0;
        end
      end
      default:
      begin
        next_state.mode = MODE_NORMAL;
      end
    endcase
    // Flags a stay in power-down longer than one refresh period
    if (in_pd)
    begin
      if (state.pd_cnt < PD_LIMIT)
      begin
        next_state.pd_cnt = state.pd_cnt + 1'b1;
      end
      else
      begin
        next_state.pd_overdue = 1'b1;
      end
    end
    else
    begin
      next_state.pd_cnt = PD_CNT_RST;
      next_state.pd_overdue = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      // Synchronisers start at the idle pin levels, so reset never reads as clock-enable low
      state <= '{cke_m: 1'b1, cke_s: 1'b1, cmd_m: CMD_RST, cmd_s: CMD_RST, mode: MODE_NORMAL,
                 exit_cnt: EXIT_CNT_RST, pd_cnt: PD_CNT_RST, pd_overdue: 1'b0, data_lost: 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign osc_link.run = (state.mode == MODE_SELF_REF);
  // Auto refresh and self refresh advance the same row counter
  assign osc_link.ext_refresh = (state.mode == MODE_NORMAL) && state.cke_s && (state.cmd_s == CMD_REFRESH);

  assign suspend_o = (state.mode == MODE_SUSPEND);
  assign self_refresh_o = (state.mode == MODE_SELF_REF);
  assign sr_exit_o = (state.mode == MODE_SR_EXIT);
  assign pd_precharge_o = (state.mode == MODE_PD_PRE);
  assign pd_active_o = (state.mode == MODE_PD_ACT);
  assign deep_pd_o = (state.mode == MODE_DEEP_PD);
  assign init_required_o = (state.mode == MODE_INIT_WAIT);
  assign cmd_enable_o = (state.mode == MODE_NORMAL);
  assign int_clk_en_o = !suspend_o;
  assign out_hold_o = suspend_o;
  assign in_buf_en_o = !(in_pd || self_refresh_o || deep_pd_o);
  assign out_buf_en_o = !(in_pd || self_refresh_o || deep_pd_o);
  assign array_power_o = !deep_pd_o;
  assign data_lost_o = state.data_lost;
  assign pd_overdue_o = state.pd_overdue;
  assign internal_refresh_o = osc_link.tick;
  assign refresh_row_o = osc_link.row;

  a_suspend_entry: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && access_busy_i) |=> suspend_o && !int_clk_en_o)
    else $error("Burst with clock-enable low did not suspend");
  a_suspend_exit: assert property (@(posedge mclk_i) disable iff (srst_i)
    (suspend_o && state.cke_s) |=> int_clk_en_o && cmd_enable_o)
    else $error("Suspend not left after clock-enable high");
  a_suspend_skip: assert property (@(posedge mclk_i) disable iff (srst_i)
    (suspend_o && !state.cke_s) |=> !int_clk_en_o && out_hold_o && !cmd_enable_o)
    else $error("Internal edge not skipped while suspended");
  a_self_ref_entry: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && !access_busy_i && !banks_open_i && state.cmd_s == CMD_REFRESH)
    |=> self_refresh_o)
    else $error("Self refresh not entered");
  a_self_ref_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    (self_refresh_o && !state.cke_s) |=> self_refresh_o && !cmd_enable_o && !in_buf_en_o)
    else $error("Self refresh left while clock-enable low");
  a_sr_exit_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
    $fell(self_refresh_o) |-> (sr_exit_o && !cmd_enable_o) [*5])
    else $error("Commands accepted too early after self refresh");
  a_pd_kind: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && !access_busy_i && state.cmd_s[3])
    |=> (pd_active_o == $past(banks_open_i)) && (pd_precharge_o != $past(banks_open_i)))
    else $error("Wrong power-down kind");
  a_pd_buffers: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pd_precharge_o || pd_active_o) |-> !in_buf_en_o && !out_buf_en_o && !cmd_enable_o)
    else $error("Buffers active in power-down");
  a_pd_exit: assert property (@(posedge mclk_i) disable iff (srst_i)
    ((pd_precharge_o || pd_active_o) && state.cke_s && cmd_nop) |=> cmd_enable_o)
    else $error("Power-down not left on no-operation");
  a_deep_pd_entry: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && !access_busy_i && !banks_open_i && state.cmd_s == CMD_DEEP_PD)
    |=> deep_pd_o && !array_power_o && data_lost_o)
    else $error("Deep power-down not entered");
  a_deep_pd_init: assert property (@(posedge mclk_i) disable iff (srst_i)
    (deep_pd_o && state.cke_s) |=> init_required_o && data_lost_o && array_power_o)
    else $error("Deep power-down exit did not require init");
  a_pd_entry_nop: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && !access_busy_i && cmd_nop) |=> pd_precharge_o || pd_active_o)
    else $error("Power-down not entered on no-operation");
  a_pd_stay: assert property (@(posedge mclk_i) disable iff (srst_i)
    (in_pd && !(state.cke_s && cmd_nop)) |=> $stable(pd_precharge_o) && $stable(pd_active_o))
    else $error("Power-down left without no-operation and clock-enable high");
  a_pd_no_refresh: assert property (@(posedge mclk_i) disable iff (srst_i)
    in_pd |-> !internal_refresh_o && !osc_link.run)
    else $error("Refresh running in power-down");
  a_pd_overdue_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    (in_pd && state.pd_cnt == PD_LIMIT) |=> pd_overdue_o)
    else $error("Overlong power-down not flagged");
  a_pd_overdue_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
    !in_pd |=> !pd_overdue_o)
    else $error("Overdue flag kept outside power-down");
  a_sr_ignore_cmd: assert property (@(posedge mclk_i) disable iff (srst_i)
    (self_refresh_o && !state.cke_s && state.cmd_s == CMD_DEEP_PD)
    |=> self_refresh_o && !deep_pd_o)
    else $error("Command acted on during self refresh");
  a_sr_exit_time: assert property (@(posedge mclk_i) disable iff (srst_i)
    (sr_exit_o && state.exit_cnt != EXIT_CNT_RST) |=> sr_exit_o && !cmd_enable_o)
    else $error("Self refresh exit time cut short");
  a_auto_refresh_row: assert property (@(posedge mclk_i) disable iff (srst_i)
    osc_link.ext_refresh |=> refresh_row_o == $past(refresh_row_o) + 1'b1)
    else $error("Auto refresh did not advance the shared row");
  a_suspend_drive: assert property (@(posedge mclk_i) disable iff (srst_i)
    suspend_o |-> out_hold_o && out_buf_en_o)
    else $error("Output data not held during suspend");
  a_deep_pd_refused: assert property (@(posedge mclk_i) disable iff (srst_i)
    (cmd_enable_o && !state.cke_s && !access_busy_i && banks_open_i && state.cmd_s == CMD_DEEP_PD)
    |=> cmd_enable_o)
    else $error("Deep power-down entered with open banks");
  a_deep_pd_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    (deep_pd_o && !state.cke_s) |=> deep_pd_o && !array_power_o && data_lost_o)
    else $error("Deep power-down left while clock-enable low");
  a_init_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
    (init_required_o && !init_done_i) |=> init_required_o && data_lost_o)
    else $error("Initialization wait left early");
endmodule

// ### testbench/slpsc_mc_model.sv
// Memory controller model driving clock-enable and the command pins
`timescale 1ns/10ps
module slpsc_mc_model
  import slpsc_pkg::*;
(
  input wire logic mclk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o
);
  initial
  begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = CMD_RST;
  end

  // One pin pattern, launched just after a rising edge
  task automatic issue(input logic cke, input logic [3:0] cmd);
    @(posedge mclk_i);
    cke_o <= cke;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd;
  endtask

  // Caller keeps banks idle before this
  task automatic sr_enter();
    issue(1'b0, CMD_REFRESH);
  endtask

  // Clock never stops here, so it is stable before clock-enable rises
  task automatic sr_leave();
    issue(1'b1, CMD_NOP);
    repeat (SR_EXIT_CYCLES) issue(1'b1, CMD_NOP);
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the low-power state control block
`timescale 1ns/10ps
module testbench;
  import slpsc_pkg::*;
  localparam int PD_LIM = 50;
  logic mclk_i, srst_i, access_busy, banks_open, init_done;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic cmd_enable, int_clk_en, out_hold, in_buf_en, out_buf_en, suspend, self_ref, sr_exit;
  logic pd_pre, pd_act, deep_pd, array_power, data_lost, init_req, pd_overdue, int_refresh;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] r0;
  logic [7:0] mvec;
  int error_cnt, num_checks, c;

  assign mvec = {cmd_enable, suspend, self_ref, sr_exit, pd_pre, pd_act, deep_pd, init_req};

  slpsc_mc_model mc (.mclk_i(mclk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n));

  slpsc_ctrl #(.PD_LIMIT_CYCLES(PD_LIM)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .access_busy_i(access_busy), .banks_open_i(banks_open),
    .init_done_i(init_done), .cmd_enable_o(cmd_enable), .int_clk_en_o(int_clk_en), .out_hold_o(out_hold),
    .in_buf_en_o(in_buf_en), .out_buf_en_o(out_buf_en), .suspend_o(suspend), .self_refresh_o(self_ref),
    .sr_exit_o(sr_exit), .pd_precharge_o(pd_pre), .pd_active_o(pd_act), .deep_pd_o(deep_pd),
    .array_power_o(array_power), .data_lost_o(data_lost), .init_required_o(init_req),
    .pd_overdue_o(pd_overdue), .internal_refresh_o(int_refresh), .refresh_row_o(row));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a mode pattern; a miss ends the run
  task automatic wait_mvec(input logic [7:0] exp, input int bound);
    int n;
    n = 0;
    #1;
    while (mvec !== exp && n < bound)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(16'(mvec), 16'(exp));
    if (mvec !== exp)
      final_report();
  endtask

  task automatic count_mode(input logic [7:0] exp, input int win, output int cnt);
    cnt = 0;
    repeat (win)
    begin
      @(posedge mclk_i);
      #1;
      if (mvec === exp)
        cnt++;
    end
  endtask

  task automatic test_suspend();
    @(posedge mclk_i);
    access_busy <= 1'b1;
    mc.issue(1'b0, CMD_NOP);
    mc.issue(1'b1, CMD_NOP);
    count_mode(8'h40, 8, c);
    chk(16'(c), 16'h0001);
    mc.issue(1'b0, CMD_NOP);
    wait_mvec(8'h40, 4);
    chk(16'({int_clk_en, out_hold}), 16'h0001);
    mc.issue(1'b0, CMD_REFRESH);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(16'(mvec), 16'h0040);
    chk(16'(row), 16'(r0));
    mc.issue(1'b1, CMD_NOP);
    wait_mvec(8'h80, 4);
    chk(16'({int_clk_en, out_hold}), 16'h0002);
    @(posedge mclk_i);
    access_busy <= 1'b0;
  endtask

  task automatic test_power_down(input logic act);
    @(posedge mclk_i);
    banks_open <= act;
    mc.issue(1'b0, act ? CMD_RST : CMD_NOP);
    wait_mvec(act ? 8'h04 : 8'h08, 4);
    chk(16'({in_buf_en, out_buf_en}), 16'h0000);
    repeat (PD_LIM - 5) @(posedge mclk_i);
    #1;
    chk(16'(pd_overdue), 16'h0000);
    repeat (10) @(posedge mclk_i);
    #1;
    chk(16'(pd_overdue), 16'h0001);
    mc.issue(1'b1, CMD_REFRESH);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(16'(mvec), act ? 16'h0004 : 16'h0008);
    mc.issue(1'b1, CMD_NOP);
    wait_mvec(8'h80, 4);
    chk(16'({in_buf_en, out_buf_en}), 16'h0003);
    @(posedge mclk_i);
    banks_open <= 1'b0;
  endtask

  task automatic test_self_refresh();
    int n;
    r0 = row;
    mc.sr_enter();
    wait_mvec(8'h20, 4);
    chk(16'({in_buf_en, out_buf_en}), 16'h0000);
    mc.issue(1'b0, CMD_DEEP_PD);
    mc.issue(1'b0, CMD_NOP);
    n = 0;
    while (int_refresh !== 1'b1 && n < SR_INTERVAL_CYCLES + 10)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(16'(int_refresh), 16'h0001);
    if (int_refresh !== 1'b1)
      final_report();
    chk(16'(mvec), 16'h0020);
    @(posedge mclk_i);
    #1;
    chk(16'(row), 16'(r0 + 12'h001));
    fork
      mc.sr_leave();
      count_mode(8'h10, 20, c);
    join
    chk(16'(c), 16'(SR_EXIT_CYCLES));
    chk(16'(mvec), 16'h0080);
    mc.issue(1'b1, CMD_REFRESH);
    mc.issue(1'b1, CMD_NOP);
    repeat (6) @(posedge mclk_i);
    #1;
    chk(16'(row), 16'(r0 + 12'h002));
  endtask

  task automatic test_deep_pd();
    @(posedge mclk_i);
    banks_open <= 1'b1;
    mc.issue(1'b0, CMD_DEEP_PD);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(16'(mvec), 16'h0080);
    @(posedge mclk_i);
    banks_open <= 1'b0;
    wait_mvec(8'h02, 4);
    chk(16'({array_power, data_lost}), 16'h0001);
    repeat (8) @(posedge mclk_i);
    #1;
    chk(16'(mvec), 16'h0002);
    mc.issue(1'b1, CMD_NOP);
    wait_mvec(8'h01, 4);
    chk(16'({array_power, data_lost}), 16'h0003);
    @(posedge mclk_i);
    init_done <= 1'b1;
    wait_mvec(8'h80, 3);
    chk(16'({array_power, data_lost}), 16'h0002);
    @(posedge mclk_i);
    init_done <= 1'b0;
  endtask

  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    srst_i = 1'b1;
    access_busy = 1'b0;
    banks_open = 1'b0;
    init_done = 1'b0;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    count_mode(8'h80, 3, c);
    chk(16'(c), 16'h0003);
    chk(16'(mvec), 16'h0080);
    chk(16'({in_buf_en, out_buf_en, array_power, int_clk_en, data_lost}), 16'h001e);
    chk(16'(row), 16'(ROW_RST));
    r0 = row;
    test_suspend();
    test_power_down(1'b0);
    test_power_down(1'b1);
    test_self_refresh();
    test_deep_pd();
    final_report();
  end
endmodule
